// [inc/cswk_pkg.sv]
/*
  Shared constants for the selective-wake status logic of CAN channel 2:
  register offsets, field positions, reset values, mode codes and widths.
  Assumes a 7-bit register address as used by the serial control port.
*/
package cswk_pkg;

  // register offsets on the 7-bit control address
  localparam logic [6:0] CSWK_ADDR_STATUS = 7'h68;
  localparam logic [6:0] CSWK_ADDR_ERRCNT = 7'h69;
  localparam logic [6:0] CSWK_ADDR_RATE_INT = 7'h6a;
  localparam logic [6:0] CSWK_ADDR_RATE_FRAC = 7'h6b;

  // status register field positions
  localparam int CSWK_BIT_SYNC = 6;
  localparam int CSWK_BIT_SILENCE = 3;
  localparam int CSWK_BIT_ACTIVE = 2;
  localparam int CSWK_BIT_PATTERN = 1;
  localparam int CSWK_BIT_FRAME = 0;

  // values after power-on or soft reset
  localparam logic [7:0] CSWK_RST_STATUS = 8'h00;
  localparam logic [7:0] CSWK_RST_ERRCNT = 8'h00;
  localparam logic [7:0] CSWK_RST_RATE_INT = 8'ha0;
  localparam logic [7:0] CSWK_RST_RATE_FRAC = 8'h00;

  // error counter width and overflow level
  localparam int CSWK_ECNT_W = 6;
  localparam logic [5:0] CSWK_ECNT_OVF = 6'h20;
  localparam logic [5:0] CSWK_ECNT_ZERO = 6'h00;

  // filtered clocks-per-bit width, split as integer 11:4 and fraction 3:0
  localparam int CSWK_AVG_W = 12;

  // transceiver mode code that never activates selective wake
  localparam logic [2:0] CSWK_MODE_NO_SWK = 3'h4;

  // answer for an unmapped address
  localparam logic [7:0] CSWK_RD_UNMAPPED = 8'h00;

  // selective-wake operating state, one-hot
  typedef enum logic [2:0] {
    CSWK_ST_OFF = 3'b001,
    CSWK_ST_ON = 3'b010,
    CSWK_ST_FAIL = 3'b100
  } cswk_state_e;

endpackage

// [design/cswk_err_counter.sv]
/*
  Frame error counter of the selective-wake logic: counts up on a frame
  error, down on a valid frame while nonzero, and stops at overflow.
  Assumes one-cycle event pulses synchronous to core_clk.
*/
`timescale 1ns/1ps
module cswk_err_counter
  import cswk_pkg::*;
#(
  parameter int WIDTH = CSWK_ECNT_W
)
(
  input wire logic core_clk, // system clock
  input wire logic reset_n, // synchronous reset, active low
  input wire logic clear, // soft reset, clears the count
  input wire logic enable, // counting allowed
  input wire logic frame_err, // one received frame had an error
  input wire logic frame_ok, // one valid base-protocol frame received
  output logic [WIDTH-1:0] count_r, // current count
  output logic overflow_r // count has reached overflow level
);

  logic [WIDTH-1:0] count_nxt;
  logic at_ovf;

  assign at_ovf = (count_r == WIDTH'(CSWK_ECNT_OVF));

  //////////////////////////////////////////////////////////////////////
  // next count; frozen at overflow so the fallback is not undone by
  // later good frames
  always_comb
  begin
    count_nxt = count_r;
    if (enable && !at_ovf)
    begin
      if (frame_err && !frame_ok)
        count_nxt = count_r + WIDTH'(1);
      else if (frame_ok && !frame_err && count_r != WIDTH'(CSWK_ECNT_ZERO))
        count_nxt = count_r - WIDTH'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // count register and overflow flag
  always_ff @(posedge core_clk)
  begin
    if (!reset_n || clear)
    begin
      count_r <= WIDTH'(CSWK_ECNT_ZERO);
      overflow_r <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      overflow_r <= (count_nxt == WIDTH'(CSWK_ECNT_OVF));
    end
  end

endmodule

// [design/cswk_status.sv]
/*
  Selective-wake status block for CAN channel 2: wake flags, activation
  state, frame error counter, recovered bit-rate and the read port of
  the four read-only status registers.
  Assumes the frame decoder delivers one-cycle event pulses and that the
  serial control interface issues single-cycle read strobes.
*/
`timescale 1ns/1ps
module cswk_status
  import cswk_pkg::*;
#(
  parameter int AVG_W = CSWK_AVG_W
)
(
  input wire logic core_clk, // 250 MHz system clock
  input wire logic reset_n, // synchronous power-on reset, active low
  input wire logic soft_reset, // soft reset pulse
  input wire logic frame_ok, // error-free valid frame received, pulse
  input wire logic frame_err, // frame with error received, pulse
  input wire logic silence_exceeded, // bus silence time exceeded, pulse
  input wire logic wake_pattern, // wake-up pattern detected, pulse
  input wire logic wake_frame, // matching wake frame detected, pulse
  input wire logic [2:0] transceiver_mode_code, // channel mode code
  input wire logic partial_wake_mode_bit, // selective wake mode chosen
  input wire logic configuration_valid_flag, // wake config is valid
  input wire logic system_error_clear, // software clears the error flag
  input wire logic [AVG_W-1:0] filtered_clocks_per_bit, // filter output
  input wire logic avg_valid, // filter output updated, pulse
  input wire logic rd_en, // register read strobe
  input wire logic [6:0] rd_addr, // register address
  output logic [7:0] rd_data_r, // read data
  output logic rd_valid_r, // read data valid, pulse
  output logic channel_system_error_flag_r, // channel system error
  output logic wake_capable_r, // plain CAN wake enabled
  output logic device_wake_r, // device wake-up request, pulse
  output logic swk_active_r // selective wake active
);

  //////////////////////////////////////////////////////////////////////
  // internal state

  cswk_state_e state_r;
  cswk_state_e state_nxt;
  logic sync_r;
  logic silence_timeout_flag_r;
  logic wake_pattern_seen_flag_r;
  logic wake_frame_seen_flag_r;
  logic [2:0] mode_prev_r;
  logic mode_seen_r;
  logic mode_change;
  logic activate;
  logic permit;
  logic [CSWK_ECNT_W-1:0] err_count;
  logic err_ovf;
  logic [7:0] clocks_per_bit_average_r;
  logic [3:0] fraction_r;
  logic clear_all;

  // soft reset acts like power-on reset for every register here
  assign clear_all = !reset_n || soft_reset;

  //////////////////////////////////////////////////////////////////////
  // helpers

  // assemble the status byte; reserved positions stay zero
  function automatic logic [7:0] pack_status(
    input logic sync,
    input logic silence,
    input logic active,
    input logic pattern,
    input logic frame
  );
    logic [7:0] v;
    v = 8'h00;
    v[CSWK_BIT_SYNC] = sync;
    v[CSWK_BIT_SILENCE] = silence;
    v[CSWK_BIT_ACTIVE] = active;
    v[CSWK_BIT_PATTERN] = pattern;
    v[CSWK_BIT_FRAME] = frame;
    return v;
  endfunction

  // a flag that hardware sets; the set wins over the clear
  function automatic logic sticky(
    input logic cur,
    input logic set,
    input logic clr
  );
    return set || (cur && !clr);
  endfunction

  //////////////////////////////////////////////////////////////////////
  // mode change detection; the first sample after reset is not a change,
  // otherwise a non-zero mode at reset release would activate by itself
  always_ff @(posedge core_clk)
  begin
    if (clear_all)
    begin
      mode_prev_r <= 3'h0;
      mode_seen_r <= 1'b0;
    end
    else
    begin
      mode_prev_r <= transceiver_mode_code;
      mode_seen_r <= 1'b1;
    end
  end

  assign mode_change = mode_seen_r &&
    (transceiver_mode_code != mode_prev_r);

  // conditions that must hold while selective wake is active
  assign permit = !channel_system_error_flag_r &&
    configuration_valid_flag && partial_wake_mode_bit;

  assign activate = mode_change && permit &&
    (transceiver_mode_code != CSWK_MODE_NO_SWK);

  //////////////////////////////////////////////////////////////////////
  // selective-wake state; fail is left only when software clears the
  // system error, so an overflowed channel cannot silently re-arm
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      CSWK_ST_OFF:
      begin
        if (activate)
          state_nxt = CSWK_ST_ON;
      end
      CSWK_ST_ON:
      begin
        if (err_ovf)
          state_nxt = CSWK_ST_FAIL;
        else if (!permit)
          state_nxt = CSWK_ST_OFF;
      end
      CSWK_ST_FAIL:
      begin
        if (system_error_clear)
          state_nxt = CSWK_ST_OFF;
      end
      default:
      begin
        state_nxt = CSWK_ST_OFF;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (clear_all)
      state_r <= CSWK_ST_OFF;
    else
      state_r <= state_nxt;
  end

  // active flag mirrors the on state
  always_ff @(posedge core_clk)
  begin
    if (clear_all)
      swk_active_r <= 1'b0;
    else
      swk_active_r <= (state_nxt == CSWK_ST_ON);
  end

  //////////////////////////////////////////////////////////////////////
  // frame error counter, counting only while selective wake runs

  cswk_err_counter #(
    .WIDTH(CSWK_ECNT_W)
  ) u_err_counter (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clear(soft_reset),
    .enable(state_r == CSWK_ST_ON),
    .frame_err(frame_err),
    .frame_ok(frame_ok),
    .count_r(err_count),
    .overflow_r(err_ovf)
  );

  //////////////////////////////////////////////////////////////////////
  // overflow fallback: system error and plain CAN wake capability;
  // an overflow in the clear cycle keeps the error flag set
  always_ff @(posedge core_clk)
  begin
    if (clear_all)
    begin
      channel_system_error_flag_r <= 1'b0;
      wake_capable_r <= 1'b0;
    end
    else
    begin
      channel_system_error_flag_r <= sticky(channel_system_error_flag_r,
        state_r == CSWK_ST_ON && err_ovf, system_error_clear);
      wake_capable_r <= sticky(wake_capable_r,
        state_r == CSWK_ST_ON && err_ovf, activate);
    end
  end

  // device wake on a pattern once the fallback is armed
  always_ff @(posedge core_clk)
  begin
    if (clear_all)
      device_wake_r <= 1'b0;
    else
      device_wake_r <= wake_capable_r && wake_pattern;
  end

  //////////////////////////////////////////////////////////////////////
  // status flags; sync is lost once selective wake stops running

  always_ff @(posedge core_clk)
  begin
    if (clear_all)
      sync_r <= 1'b0;
    else
      sync_r <= sticky(sync_r, frame_ok && state_r == CSWK_ST_ON,
        state_r != CSWK_ST_ON);
  end

  // silence flag: bus activity with a good frame ends the silence
  always_ff @(posedge core_clk)
  begin
    if (clear_all)
      silence_timeout_flag_r <= 1'b0;
    else
      silence_timeout_flag_r <= sticky(silence_timeout_flag_r,
        silence_exceeded && state_r == CSWK_ST_ON, frame_ok);
  end

  // wake event flags stay until reset
  always_ff @(posedge core_clk)
  begin
    if (clear_all)
    begin
      wake_pattern_seen_flag_r <= 1'b0;
      wake_frame_seen_flag_r <= 1'b0;
    end
    else
    begin
      wake_pattern_seen_flag_r <= sticky(wake_pattern_seen_flag_r,
        wake_pattern, 1'b0);
      wake_frame_seen_flag_r <= sticky(wake_frame_seen_flag_r,
        wake_frame && state_r == CSWK_ST_ON, 1'b0);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // recovered bit rate, held between filter updates
  always_ff @(posedge core_clk)
  begin
    if (clear_all)
    begin
      clocks_per_bit_average_r <= CSWK_RST_RATE_INT;
      fraction_r <= CSWK_RST_RATE_FRAC[7:4];
    end
    else if (avg_valid)
    begin
      clocks_per_bit_average_r <= filtered_clocks_per_bit[11:4];
      fraction_r <= filtered_clocks_per_bit[3:0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read port; a read only samples, it has no side effect on any state
  always_ff @(posedge core_clk)
  begin
    if (clear_all)
    begin
      rd_data_r <= CSWK_RST_STATUS;
      rd_valid_r <= 1'b0;
    end
    else
    begin
      rd_valid_r <= rd_en;
      if (rd_en)
      begin
        case (rd_addr)
          CSWK_ADDR_STATUS:
            rd_data_r <= pack_status(sync_r, silence_timeout_flag_r,
              swk_active_r, wake_pattern_seen_flag_r,
              wake_frame_seen_flag_r);
          CSWK_ADDR_ERRCNT:
            rd_data_r <= {2'h0, err_count};
          CSWK_ADDR_RATE_INT:
            rd_data_r <= clocks_per_bit_average_r;
          CSWK_ADDR_RATE_FRAC:
            rd_data_r <= {fraction_r, 4'h0};
          default:
            rd_data_r <= CSWK_RD_UNMAPPED;
        endcase
      end
    end
  end

endmodule

// [tb/cswk_status_checker.sv]
/*
  Port assertions for the channel-2 selective-wake status block.
  Assumes synchronous resets and one-cycle read strobes; bound below.
*/
`timescale 1ns/1ps
module cswk_status_checker
  import cswk_pkg::*;
#(
  parameter int AVG_W = CSWK_AVG_W
)
(
  input wire logic core_clk, // clock
  input wire logic reset_n, // reset, active low
  input wire logic soft_reset, // soft reset
  input wire logic frame_ok, // valid frame
  input wire logic frame_err, // errored frame
  input wire logic silence_exceeded, // silence pulse
  input wire logic wake_pattern, // wake pattern
  input wire logic wake_frame, // wake frame
  input wire logic [2:0] transceiver_mode_code, // mode code
  input wire logic partial_wake_mode_bit, // wake mode chosen
  input wire logic configuration_valid_flag, // config valid
  input wire logic system_error_clear, // error clear
  input wire logic [AVG_W-1:0] filtered_clocks_per_bit, // filter value
  input wire logic avg_valid, // filter update
  input wire logic rd_en, // read strobe
  input wire logic [6:0] rd_addr, // read address
  input wire logic [7:0] rd_data_r, // read data
  input wire logic rd_valid_r, // read valid
  input wire logic channel_system_error_flag_r, // system error
  input wire logic wake_capable_r, // plain wake armed
  input wire logic device_wake_r, // wake request
  input wire logic swk_active_r // selective wake active
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n || soft_reset);
  ////////////////////////////////////////////////////////////////////
  // read answer and reserved fields
  chk_read_latency: assert property (rd_en |=> rd_valid_r)
    else $error("read answer missing");
  chk_status_rsvd: assert property (rd_valid_r &&
    $past(rd_addr) == CSWK_ADDR_STATUS |-> rd_data_r[7] == 1'b0 &&
    rd_data_r[5:4] == 2'h0 && rd_data_r[2] == $past(swk_active_r))
    else $error("status read wrong");
  chk_count_rsvd: assert property (rd_valid_r &&
    $past(rd_addr) == CSWK_ADDR_ERRCNT |-> rd_data_r <= 8'h20)
    else $error("counter read out of range");
  chk_frac_rsvd: assert property (rd_valid_r &&
    $past(rd_addr) == CSWK_ADDR_RATE_FRAC |-> rd_data_r[3:0] == 4'h0)
    else $error("fraction low bits set");
  // activation and fallback; a lost permit must drop activity at once
  chk_active_drop: assert property (!partial_wake_mode_bit ||
    !configuration_valid_flag |=> !swk_active_r)
    else $error("active without permit");
  chk_mode4_hold: assert property ($changed(transceiver_mode_code) &&
    transceiver_mode_code == CSWK_MODE_NO_SWK && !swk_active_r
    |=> !swk_active_r)
    else $error("mode 4 activated");
  chk_fail_state: assert property (channel_system_error_flag_r
    |-> wake_capable_r && !swk_active_r)
    else $error("fallback incomplete");
  chk_wake_pulse: assert property (wake_capable_r && wake_pattern
    |=> device_wake_r)
    else $error("no device wake");
  chk_reset_value: assert property (disable iff (1'b0) !reset_n
    |=> !rd_valid_r && rd_data_r == 8'h00 && !swk_active_r &&
    !channel_system_error_flag_r && !wake_capable_r)
    else $error("reset values wrong");
  cov_active: cover property ($rose(swk_active_r));
  cov_wake: cover property (device_wake_r);
  cov_fail: cover property ($rose(channel_system_error_flag_r));
endmodule
bind cswk_status cswk_status_checker #(.AVG_W(AVG_W)) u_chk (.*);

// [tb/cswk_bus_node.sv]
/*
  Bus-side event source standing in for the CAN nodes and the decoder.
  Drives one-cycle pulses on the falling edge of core_clk.
*/
`timescale 1ns/1ps
module cswk_bus_node
(
  input wire logic core_clk, // clock
  output logic frame_ok, // valid frame seen
  output logic frame_err, // errored frame seen
  output logic silence_exceeded, // bus idle too long
  output logic wake_pattern, // wake pattern seen
  output logic wake_frame // matching wake frame seen
);
  logic [4:0] ev;
  assign {wake_frame, wake_pattern, silence_exceeded, frame_err} = ev[4:1];
  assign frame_ok = ev[0];
  initial ev = 5'h00;
  // n pulses of one kind; gap gives a slow bus idle cycles between
  task automatic send(input int kind, input int n, input int gap);
    for (int i = 0; i < n; i++)
    begin
      @(negedge core_clk);
      ev[kind] = 1'b1;
      @(negedge core_clk);
      ev[kind] = 1'b0;
      repeat (gap) @(negedge core_clk);
    end
  endtask
endmodule

// [tb/can_selective_wake_status_ch2_tb.sv]
/*
  Self-checking bench for the channel-2 selective-wake status block.
  Inputs change on the falling edge; registers are read via rd_en.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
  fail_count++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module can_selective_wake_status_ch2_tb
  import cswk_pkg::*;
;
  logic core_clk, reset_n, soft_reset, sys_clr, avg_valid, rd_en;
  logic pwm, cfg, rd_valid_r, syserr, wcap, dwake, active;
  logic ok, err, sil, wp, wf;
  logic [2:0] mode;
  logic [11:0] avg;
  logic [6:0] rd_addr;
  logic [7:0] rd_data_r, got;
  int fail_count, n_tests;
  ////////////////////////////////////////////////////////////////////
  cswk_bus_node node (.core_clk(core_clk), .frame_ok(ok), .frame_err(err),
    .silence_exceeded(sil), .wake_pattern(wp), .wake_frame(wf));
  cswk_status #(.AVG_W(12)) DUT (.core_clk(core_clk), .reset_n(reset_n),
    .soft_reset(soft_reset), .frame_ok(ok), .frame_err(err),
    .silence_exceeded(sil), .wake_pattern(wp), .wake_frame(wf),
    .transceiver_mode_code(mode), .partial_wake_mode_bit(pwm),
    .configuration_valid_flag(cfg), .system_error_clear(sys_clr),
    .filtered_clocks_per_bit(avg), .avg_valid(avg_valid), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
    .channel_system_error_flag_r(syserr), .wake_capable_r(wcap),
    .device_wake_r(dwake), .swk_active_r(active));
  // 4 ns clock
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // one read; data stands from the edge after the strobe
  task automatic chk_rd(input logic [6:0] a, input logic [7:0] e,
    input string nm);
    @(negedge core_clk);
    rd_en = 1'b1;
    rd_addr = a;
    @(negedge core_clk);
    rd_en = 1'b0;
    got = rd_data_r;
    `CHK("rd_valid", 1'b1, rd_valid_r);
    `CHK(nm, e, got);
  endtask
  // one-cycle pulse on a control input
  task automatic pulse(ref logic s);
    @(negedge core_clk);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk_rd(7'h68, 8'h00, "status");
    chk_rd(7'h69, 8'h00, "errcnt");
    chk_rd(7'h6a, 8'ha0, "rate_int");
    chk_rd(7'h6b, 8'h00, "rate_frac");
    chk_rd(7'h00, 8'h00, "unmapped");
    $display("t_reset done");
  endtask
  task automatic t_activate();
    pwm = 1'b1;
    cfg = 1'b1;
    mode = 3'h4;
    repeat (3) @(negedge core_clk);
    chk_rd(7'h68, 8'h00, "mode4 status");
    mode = 3'h3;
    repeat (2) @(negedge core_clk);
    chk_rd(7'h68, 8'h04, "active status");
    `CHK("active", 1'b1, active);
    node.send(0, 1, 0);
    chk_rd(7'h68, 8'h44, "sync status");
    node.send(2, 1, 0);
    chk_rd(7'h68, 8'h4c, "silence status");
    node.send(4, 1, 0);
    chk_rd(7'h68, 8'h4d, "frame status");
    node.send(3, 1, 0);
    chk_rd(7'h68, 8'h4f, "pattern status");
    chk_rd(7'h68, 8'h4f, "reread status");
    $display("t_activate done");
  endtask
  // counts up, down, to overflow, then the plain wake fallback
  task automatic t_counter();
    node.send(1, 3, 0);
    chk_rd(7'h69, 8'h03, "errcnt 3");
    node.send(0, 1, 1);
    chk_rd(7'h69, 8'h02, "errcnt dec");
    node.send(1, 30, 0);
    repeat (3) @(negedge core_clk);
    chk_rd(7'h69, 8'h20, "errcnt ovf");
    `CHK("syserr", 1'b1, syserr);
    `CHK("wake_capable", 1'b1, wcap);
    chk_rd(7'h68, 8'h03, "fail status");
    node.send(0, 1, 0);
    chk_rd(7'h69, 8'h20, "errcnt frozen");
    node.send(3, 1, 0);
    `CHK("device_wake", 1'b1, dwake);
    pulse(sys_clr);
    `CHK("syserr clr", 1'b0, syserr);
    `CHK("device_wake end", 1'b0, dwake);
    $display("t_counter done");
  endtask
  task automatic t_rate();
    avg = 12'hab5;
    pulse(avg_valid);
    chk_rd(7'h6a, 8'hab, "rate_int");
    chk_rd(7'h6b, 8'h50, "rate_frac");
    pulse(soft_reset);
    chk_rd(7'h68, 8'h00, "soft status");
    chk_rd(7'h69, 8'h00, "soft errcnt");
    chk_rd(7'h6a, 8'ha0, "soft rate_int");
    chk_rd(7'h6b, 8'h00, "soft rate_frac");
    $display("t_rate done");
  endtask
  // a lost permit while active must have dropped the active flag two cycles later
  task automatic t_permit();
    mode = 3'h5;
    repeat (2) @(negedge core_clk);
    `CHK("active on", 1'b1, active);
    cfg = 1'b0;
    repeat (2) @(negedge core_clk);
    `CHK("active drop", 1'b0, active);
    chk_rd(7'h68, 8'h00, "drop status");
    $display("t_permit done");
  endtask
  ////////////////////////////////////////////////////////////////////
  // main sequence after a 4-cycle reset
  initial
  begin
    {reset_n, soft_reset, sys_clr, avg_valid, rd_en, pwm, cfg} = 7'h00;
    mode = 3'h0;
    avg = 12'h000;
    rd_addr = 7'h00;
    fail_count = 0;
    n_tests = 0;
    repeat (4) @(negedge core_clk);
    reset_n = 1'b1;
    t_reset();
    t_activate();
    t_counter();
    t_rate();
    t_permit();
    test_done();
  end
  // hang guard, well beyond the roughly 160 cycles used
  initial
  begin
    #20000;
    fail_count++;
    test_done();
  end
endmodule
